// ==== adc_port_params.svh ====
// Purpose: offsets, clock select codes, reset values and timing counts
// Assumes: 32-bit apb words, printed offsets are register indexes
// Notes: byte address is four times the index
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH
`define IDX_PORT_A_PINS 8'h05
`define IDX_CTRL_A 8'h08
`define IDX_INTCTL 8'h0B
`define IDX_INTCTL_HI 8'h8B
`define IDX_PFLAGS 8'h0C
`define IDX_RESULT_B 8'h1E
`define IDX_CTRL_B 8'h1F
`define IDX_PORT_A_DIR 8'h85
`define IDX_PINCFG_A 8'h88
`define IDX_RESULT_A 8'h89
`define IDX_PENABLES 8'h8C
`define IDX_PINCFG_B 8'h9F
`define IDX_VARIANT 8'hC0
`define DIR_RESET 5'h1F
`define CTRL_RESET 8'h00
`define CLK_HZ 25000000
`define RC_PERIOD_NS 4000
`define RC_CYCLES ((`RC_PERIOD_NS * 25) / 1000)
`define DIV_SEL_2 2'h0
`define DIV_SEL_8 2'h1
`define DIV_SEL_32 2'h2
`define DIV_SEL_RC 2'h3
`define CONV_HALF_PERIODS 5'h13
`endif

// ==== adc_port_pkg.sv ====
// Purpose: types for the converter control block
// Assumes: constants live in adc_port_params.svh
// Notes: none
package adc_port_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONVERT = 2'b01
   } conv_state_t;
   typedef struct packed {
      logic [1:0] clock_select;
      logic [2:0] channel;
      logic go_done;
      logic done_flag_a;
      logic module_on;
   } conv_ctrl_t;
endpackage

// ==== adc_port_clock_control.sv ====
// Purpose: converter control, pin configuration and clock selection
// Assumes: the analog sampler outputs an 8-bit code for the selected pin
// Notes: variant input chooses first (0) or second (1) register layout
//
// Function
// [RL1] software sets direction bit to input on pins it will convert
// [RL2] an output-driven analog pin converts its own driven level
// [RL3] conversion proceeds regardless of channel select and direction bits
// [RL4] port data reads zero on every pin configured as analog input
// [RL5] a digital input pin can still be selected and converted
// [RL6] clock select: 00 2 osc, 01 8 osc, 10 32 osc, 11 rc
// [RL7] rc clock gives a per-bit period of about 4 us
// [RL8] above 1 MHz software uses rc clock only in sleep
// [RL9] software avoids dividers yielding per-bit period below minimum
// [RL10] software picks faster clock when per-bit period is very long
// [RL11] first variant control layout, bit 5 unused, resets zero
// [RL12] second variant control layout, bit 1 unused, resets zero
// [RL13] second variant flag and enable at bit 6 of peripheral registers
// [RL14] first variant irq enable is bit 6 of mirrored interrupt control
// [RL15] two-bit port configuration field resets to 00 on every reset
// [RL16] result register undefined at power-on, kept over other resets
// [RL17] unimplemented converter register bits read zero
// [RL18] five direction bits reset to ones on every reset
// [RL19] on completion load result, clear go/done, set done flag
// [RL20] one conversion lasts nine and a half per-bit periods
// [RL21] software picks per-bit period of at least 1.6 us
// [RL22] software waits two per-bit periods before next acquisition
// [RL23] go/done write with module on starts and holds until done
// [RL24] clearing module on stops clock and sequencing, result kept
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "adc_port_params.svh"
module adc_port_clock_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic variant,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe,
   output logic [2:0] sample_channel,
   input wire logic [7:0] sample_code,
   output logic conv_active
);
   logic [4:0] pin_s1, pin_s2, pin_s3;
   logic [4:0] port_latch, next_port_latch;
   logic [4:0] dir, next_dir;
   adc_port_pkg::conv_ctrl_t ctrl, next_ctrl;
   logic [1:0] pcfg, next_pcfg;
   logic [7:0] intctl, next_intctl;
   logic pflag, next_pflag;
   logic pen, next_pen;
   logic [7:0] result, next_result;
   adc_port_pkg::conv_state_t state, next_state;
   logic [7:0] div_cnt, next_div_cnt;
   logic [4:0] half_cnt, next_half_cnt;
   logic [31:0] next_prdata;
   logic [4:0] analog_mask;
   logic [4:0] pin_view;
   logic [7:0] tick_div;
   logic [7:0] idx;
   logic wr, rd, tick, done_evt, start;
   logic [7:0] ctrl_a_rd, ctrl_b_rd;
   logic [4:0] port_out, next_port_out;

   assign idx = paddr[9:2];
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;

   // pins from outside: three stages, change taken when stages 2 and 3 agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
         pin_s3 <= 5'h00;
         port_latch <= 5'h00;
      end else begin
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         port_latch <= next_port_latch;
      end
   end
   always_comb begin
      next_port_latch = port_latch;
      for (int i = 0; i < 5; i++) begin
         if (pin_s2[i] == pin_s3[i]) begin
            next_port_latch[i] = pin_s3[i];
         end
      end
   end

   // analog pins by configuration field; ra4 is always digital
   always_comb begin
      unique case (pcfg)
         2'h0: analog_mask = 5'h0F;
         2'h1: analog_mask = 5'h0F;
         2'h2: analog_mask = 5'h03;
         2'h3: analog_mask = 5'h00;
      endcase
   end
   // output pins read back their driven level
   assign pin_view = (port_latch & dir) | (pin_out & ~dir);

   // conversion clock divider; rc source approximated by a fixed count
   always_comb begin
      unique case (ctrl.clock_select) // RL6
         `DIV_SEL_2: tick_div = 8'h01;
         `DIV_SEL_8: tick_div = 8'h04;
         `DIV_SEL_32: tick_div = 8'h10;
         `DIV_SEL_RC: tick_div = 8'(`RC_CYCLES / 2); // RL7
      endcase
   end
   // tick is a half per-bit period so 9.5 periods is a whole count
   // at or past the end: a slower-to-faster select change mid-run must not wrap through 255
   assign tick = ctrl.module_on && (div_cnt >= tick_div - 8'h01); // RL24
   assign start = wr && ((idx == `IDX_CTRL_A && !variant) || (idx == `IDX_CTRL_B && variant))
      && pwdata[2] && pwdata[0] && state == adc_port_pkg::ST_IDLE; // RL23
   assign done_evt = state == adc_port_pkg::ST_CONVERT && tick
      && half_cnt == `CONV_HALF_PERIODS - 5'h01; // RL20

   always_comb begin
      next_state = state;
      next_div_cnt = ctrl.module_on ? (tick ? 8'h00 : div_cnt + 8'h01) : 8'h00; // RL24
      next_half_cnt = half_cnt;
      unique case (state)
         adc_port_pkg::ST_IDLE: begin
            next_half_cnt = 5'h00;
            if (start) begin
               next_state = adc_port_pkg::ST_CONVERT; // RL3
               next_div_cnt = 8'h00;
            end
         end
         adc_port_pkg::ST_CONVERT: begin
            if (!ctrl.module_on) begin
               next_state = adc_port_pkg::ST_IDLE; // RL24
            end else if (done_evt) begin
               next_state = adc_port_pkg::ST_IDLE;
            end else if (tick) begin
               next_half_cnt = half_cnt + 5'h01;
            end
         end
         default: next_state = adc_port_pkg::ST_IDLE;
      endcase
   end

   // register writes and completion effects
   always_comb begin
      next_dir = dir;
      next_ctrl = ctrl;
      next_pcfg = pcfg;
      next_intctl = intctl;
      next_pflag = pflag;
      next_pen = pen;
      next_result = result;
      next_port_out = port_out;
      if (wr) begin
         unique case (idx)
            `IDX_PORT_A_PINS: next_port_out = pwdata[4:0];
            `IDX_PORT_A_DIR: next_dir = pwdata[4:0];
            `IDX_INTCTL, `IDX_INTCTL_HI: next_intctl = pwdata[7:0]; // RL14
            `IDX_CTRL_A: if (!variant) begin
               next_ctrl.clock_select = pwdata[7:6]; // RL11
               next_ctrl.channel = {1'b0, pwdata[4:3]};
               next_ctrl.go_done = ctrl.go_done | (pwdata[2] & pwdata[0]);
               next_ctrl.done_flag_a = pwdata[1];
               next_ctrl.module_on = pwdata[0];
            end
            `IDX_CTRL_B: if (variant) begin
               next_ctrl.clock_select = pwdata[7:6]; // RL12
               next_ctrl.channel = pwdata[5:3];
               next_ctrl.go_done = ctrl.go_done | (pwdata[2] & pwdata[0]);
               next_ctrl.module_on = pwdata[0];
            end
            `IDX_PINCFG_A: if (!variant) next_pcfg = pwdata[1:0]; // RL15
            `IDX_PINCFG_B: if (variant) next_pcfg = pwdata[1:0]; // RL15
            `IDX_PFLAGS: if (variant) next_pflag = pwdata[6]; // RL13
            `IDX_PENABLES: if (variant) next_pen = pwdata[6]; // RL13
            `IDX_RESULT_A, `IDX_RESULT_B: next_result = pwdata[7:0];
            default: next_result = result;
         endcase
      end
      // software clear of go/done aborts nothing once module is off
      if (!ctrl.module_on && !next_ctrl.module_on) begin
         next_ctrl.go_done = 1'b0; // RL24
      end
      // completion wins over a same-cycle software clear
      if (done_evt) begin
         next_result = sample_code; // RL19 RL2 RL5
         next_ctrl.go_done = 1'b0; // RL19
         if (variant) begin
            next_pflag = 1'b1; // RL13
         end else begin
            next_ctrl.done_flag_a = 1'b1; // RL19
         end
      end
   end

   assign ctrl_a_rd = {ctrl.clock_select, 1'b0, ctrl.channel[1:0], ctrl.go_done,
      ctrl.done_flag_a, ctrl.module_on}; // RL17
   assign ctrl_b_rd = {ctrl.clock_select, ctrl.channel, ctrl.go_done, 1'b0,
      ctrl.module_on}; // RL17

   always_comb begin
      next_prdata = 32'h0000_0000; // RL17
      if (rd) begin
         unique case (idx)
            `IDX_PORT_A_PINS: next_prdata = {27'h0, pin_view & ~analog_mask}; // RL4
            `IDX_PORT_A_DIR: next_prdata = {27'h0, dir};
            `IDX_INTCTL, `IDX_INTCTL_HI: next_prdata = {24'h0, intctl};
            `IDX_CTRL_A: if (!variant) next_prdata = {24'h0, ctrl_a_rd};
            `IDX_CTRL_B: if (variant) next_prdata = {24'h0, ctrl_b_rd};
            `IDX_PINCFG_A: if (!variant) next_prdata = {30'h0, pcfg};
            `IDX_PINCFG_B: if (variant) next_prdata = {30'h0, pcfg};
            `IDX_PFLAGS: if (variant) next_prdata = {25'h0, pflag, 6'h00};
            `IDX_PENABLES: if (variant) next_prdata = {25'h0, pen, 6'h00};
            `IDX_RESULT_A: if (!variant) next_prdata = {24'h0, result};
            `IDX_RESULT_B: if (variant) next_prdata = {24'h0, result};
            `IDX_VARIANT: next_prdata = {31'h0, variant};
            default: next_prdata = 32'h0000_0000;
         endcase
      end else begin
         next_prdata = prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir <= `DIR_RESET; // RL18
         ctrl <= `CTRL_RESET; // RL11 RL12
         pcfg <= 2'h0; // RL15
         intctl <= 8'h00;
         pflag <= 1'b0;
         pen <= 1'b0;
         port_out <= 5'h00;
         state <= adc_port_pkg::ST_IDLE;
         div_cnt <= 8'h00;
         half_cnt <= 5'h00;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pin_out <= 5'h00;
         pin_oe <= 5'h00;
         sample_channel <= 3'h0;
         conv_active <= 1'b0;
      end else begin
         dir <= next_dir;
         ctrl <= next_ctrl;
         pcfg <= next_pcfg;
         intctl <= next_intctl;
         pflag <= next_pflag;
         pen <= next_pen;
         port_out <= next_port_out;
         state <= next_state;
         div_cnt <= next_div_cnt;
         half_cnt <= next_half_cnt;
         prdata <= next_prdata;
         pready <= psel && !penable;
         pslverr <= 1'b0;
         pin_out <= next_port_out;
         pin_oe <= ~next_dir;
         sample_channel <= next_ctrl.channel; // RL3
         conv_active <= next_state == adc_port_pkg::ST_CONVERT;
      end
   end

   // result has no reset: undefined at power-on, kept across other resets
   always_ff @(posedge pclk) begin
      result <= next_result; // RL16
   end

   // result has no reset, so the hold check waits for a first known value
   logic result_known, next_result_known;
   always_comb begin
      next_result_known = result_known;
      if (done_evt || (wr && (idx == `IDX_RESULT_A || idx == `IDX_RESULT_B))) begin
         next_result_known = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_known <= 1'b0;
      end else begin
         result_known <= next_result_known;
      end
   end

   // conversion start, completion, holds, module off and counter ranges
   AST_DONE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      done_evt |=> !ctrl.go_done) else $error("go/done not cleared"); // RL19
   AST_DONE_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
      done_evt |=> result == $past(sample_code)) else $error("result not loaded"); // RL19
   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
      done_evt && variant |=> pflag) else $error("done flag not set"); // RL13
   AST_OFF_STOPS: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl.module_on |=> div_cnt == 8'h00) else $error("clock runs while off"); // RL24
   AST_START: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> ctrl.go_done && state == adc_port_pkg::ST_CONVERT) else $error("no start"); // RL23
   AST_HOLD_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
      result_known && !done_evt && !wr |=> $stable(result)) else $error("result changed"); // RL24
   AST_FLAG_A_SET: assert property (@(posedge pclk) disable iff (!presetn)
      done_evt && !variant |=> ctrl.done_flag_a)
      else $error("first layout done flag not set"); // RL19
   AST_GO_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      state == adc_port_pkg::ST_CONVERT && ctrl.module_on |-> ctrl.go_done)
      else $error("go/done dropped mid conversion"); // RL23
   AST_HALF_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
      state == adc_port_pkg::ST_CONVERT |-> half_cnt < `CONV_HALF_PERIODS)
      else $error("half tick count overran"); // RL20
   AST_TICK_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      !ctrl.module_on |-> !tick)
      else $error("tick while module off"); // RL24
   AST_DIV_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl.module_on && $stable(ctrl.clock_select) |-> div_cnt < tick_div)
      else $error("divider count out of range"); // RL6

   // reset values, seen at the first edge after release
   AST_DIR_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> dir == `DIR_RESET)
      else $error("direction reset wrong"); // RL18
   AST_PCFG_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> pcfg == 2'h0)
      else $error("port configuration reset wrong"); // RL15
   AST_CTRL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> ctrl == `CTRL_RESET)
      else $error("control reset wrong"); // RL11

   // pins, channel, outputs and register access
   AST_PIN_OE: assert property (@(posedge pclk) disable iff (!presetn)
      pin_oe == ~dir)
      else $error("output enable disagrees with direction"); // RL2
   AST_PIN_OUT: assert property (@(posedge pclk) disable iff (!presetn)
      pin_out == port_out)
      else $error("pin output disagrees with port data"); // RL2
   AST_CHANNEL: assert property (@(posedge pclk) disable iff (!presetn)
      sample_channel == ctrl.channel)
      else $error("sampled channel disagrees with select"); // RL3
   AST_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
      conv_active == (state == adc_port_pkg::ST_CONVERT))
      else $error("active flag disagrees with state"); // RL23
   AST_PEN_HIDDEN: assert property (@(posedge pclk) disable iff (!presetn)
      wr && idx == `IDX_PENABLES && !variant |=> $stable(pen))
      else $error("hidden enable register written"); // RL13
   AST_BIT1_ZERO_B: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == `IDX_CTRL_B |=> prdata[1] == 1'b0)
      else $error("second layout unused bit set"); // RL17
   AST_ANALOG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == `IDX_PORT_A_PINS |=> (prdata[4:0] & $past(analog_mask)) == 5'h00)
      else $error("analog pin read nonzero"); // RL4
   AST_BIT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      rd && idx == `IDX_CTRL_A |=> prdata[5] == 1'b0) else $error("unused bit set"); // RL17
   COV_CONV: cover property (@(posedge pclk) disable iff (!presetn) done_evt);
   COV_OFF: cover property (@(posedge pclk) disable iff (!presetn)
      state == adc_port_pkg::ST_CONVERT && !ctrl.module_on);
   COV_RC: cover property (@(posedge pclk) disable iff (!presetn)
      done_evt && ctrl.clock_select == `DIV_SEL_RC);
   COV_VARIANT_B: cover property (@(posedge pclk) disable iff (!presetn)
      done_evt && variant);
   COV_DRIVEN_PIN: cover property (@(posedge pclk) disable iff (!presetn)
      done_evt && pin_oe[0] && sample_channel == 3'h0);
endmodule

// ==== analog_source_model.sv ====
// Purpose: analog sources standing on the five port pins
// Assumes: one 8-bit level for each pin, set by the bench
// Notes: a driven pin converts its own full-scale digital level
`timescale 1ns/100ps
module analog_source_model (
   input wire logic [39:0] levels,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [2:0] sample_channel,
   output logic [4:0] pin_in,
   output logic [7:0] sample_code
);
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : levels[i * 8 + 7];
      end
      // channels with no pin behind them see a fixed pattern, never a settled zero
      if (sample_channel > 3'h4) begin
         sample_code = 8'hA5;
      end else if (pin_oe[sample_channel]) begin
         sample_code = {8{pin_out[sample_channel]}};
      end else begin
         sample_code = levels[sample_channel * 8 +: 8];
      end
   end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: apb byte address is four times the register index
// Notes: random levels from a fixed seed, corner cases by hand
`timescale 1ns/100ps
`include "adc_port_params.svh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic variant = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, conv_active, pslverr;
   logic [4:0] pin_in, pin_out, pin_oe;
   logic [2:0] sample_channel;
   logic [7:0] sample_code, kept;
   logic [39:0] levels = 40'h0;
   integer seed = 32'hCBA8;
   int error_cnt = 0;
   int n_checks = 0;
   int ch;
   always #20 pclk = ~pclk;
   adc_port_clock_control dut (.pclk(pclk), .presetn(presetn), .por_n(1'b1),
      .variant(variant), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .sample_channel(sample_channel),
      .sample_code(sample_code), .conv_active(conv_active));
   analog_source_model src (.levels(levels), .pin_out(pin_out), .pin_oe(pin_oe),
      .sample_channel(sample_channel), .pin_in(pin_in), .sample_code(sample_code));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {22'h0, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         error_cnt++;
         stop_test();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      check(what, rd, exp);
   endtask
   // nineteen half ticks, a half tick being half the divider in clocks
   function automatic int conv_len(input logic [1:0] cs);
      case (cs)
         `DIV_SEL_2: return 19;
         `DIV_SEL_8: return 19 * 4;
         `DIV_SEL_32: return 19 * 16;
         default: return 19 * `RC_CYCLES / 2;
      endcase
   endfunction
   task automatic convert(input logic [7:0] idx, input logic [7:0] ctl, input int len);
      int n;
      apb(1'b1, idx, {24'h0, ctl});
      n = 0;
      while ((conv_active === 1'b1 || n < 2) && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      check("conv_len", 32'(n + 3 >= len && n <= len + 1), 32'h1);
      repeat (len * 4 / 19) @(posedge pclk);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("ctrl", `IDX_CTRL_A, 32'h0);
      rchk("pincfg", `IDX_PINCFG_A, 32'h0);
      rchk("dir", `IDX_PORT_A_DIR, 32'h1F);
      apb(1'b1, 8'h40, 32'hFF);
      rchk("unmapped", 8'h40, 32'h0);
      check("pslverr", 32'(pslverr), 32'h0);
      for (int cs = 0; cs < 4; cs++) begin
         levels <= 40'({$random(seed), $random(seed)});
         ch = {$random(seed)} % 4;
         convert(`IDX_CTRL_A, {2'(cs), 1'b1, 2'(ch), 3'b101}, conv_len(2'(cs)));
         rchk("ctrl", `IDX_CTRL_A, {24'h0, 2'(cs), 1'b0, 2'(ch), 3'b011});
         rchk("result", `IDX_RESULT_A, 32'(levels[ch * 8 +: 8]));
      end
      apb(1'b1, `IDX_PORT_A_DIR, 32'h1E);
      apb(1'b1, `IDX_PORT_A_PINS, 32'h1);
      check("pin_oe", 32'(pin_oe), 32'h1);
      check("pin_out", 32'(pin_out), 32'h1);
      convert(`IDX_CTRL_A, 8'h05, 19);
      rchk("result", `IDX_RESULT_A, 32'hFF);
      rchk("port", `IDX_PORT_A_PINS, {27'h0, levels[39], 4'h0});
      apb(1'b1, `IDX_PORT_A_DIR, 32'h1F);
      apb(1'b1, `IDX_PINCFG_A, 32'h2);
      rchk("port", `IDX_PORT_A_PINS,
         {27'h0, levels[39], levels[31], levels[23], 2'h0});
      apb(1'b1, `IDX_PINCFG_A, 32'h3);
      rchk("port", `IDX_PORT_A_PINS,
         {27'h0, levels[39], levels[31], levels[23], levels[15], levels[7]});
      convert(`IDX_CTRL_A, 8'h15, 19);
      rchk("result", `IDX_RESULT_A, 32'(levels[23:16]));
      apb(1'b1, `IDX_INTCTL, 32'h40);
      rchk("intctl", `IDX_INTCTL_HI, 32'h40);
      levels <= {levels[39:8], ~levels[23:16]};
      apb(1'b1, `IDX_CTRL_A, 32'h85);
      repeat (50) @(posedge pclk);
      apb(1'b1, `IDX_CTRL_A, 32'h80);
      repeat (400) @(posedge pclk);
      check("active", 32'(conv_active), 32'h0);
      rchk("result", `IDX_RESULT_A, 32'(levels[23:16]));
      apb(1'b0, `IDX_CTRL_A, 32'h0);
      check("flag", 32'(rd[1]), 32'h0);
      kept = levels[23:16];
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk("result", `IDX_RESULT_A, 32'(kept));
      rchk("dir", `IDX_PORT_A_DIR, 32'h1F);
      rchk("pincfg", `IDX_PINCFG_A, 32'h0);
      variant <= 1'b1;
      @(posedge pclk);
      rchk("ctrl_b", `IDX_CTRL_B, 32'h0);
      rchk("pflags", `IDX_PFLAGS, 32'h0);
      convert(`IDX_CTRL_B, 8'h27, 19);
      check("channel", 32'(sample_channel), 32'h4);
      rchk("ctrl_b", `IDX_CTRL_B, 32'h21);
      rchk("pflags", `IDX_PFLAGS, 32'h40);
      rchk("result_b", `IDX_RESULT_B, 32'(levels[39:32]));
      apb(1'b1, `IDX_PENABLES, 32'hFF);
      rchk("penables", `IDX_PENABLES, 32'h40);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      stop_test();
   end
endmodule
